// ===== verilog/tlic_defines.svh
// Register addresses, reset values, field positions and vectors of the interrupt controller
`ifndef TLIC_DEFINES_SVH
`define TLIC_DEFINES_SVH
`define TLIC_ADDR_ENABLE 8'hA8
`define TLIC_ADDR_LEVEL 8'hB8
`define TLIC_ADDR_AUX 8'hA9
`define TLIC_RST_ENABLE 8'h00
`define TLIC_RST_LEVEL 8'h00
`define TLIC_RST_AUX 8'hA0
`define TLIC_AUX_WMASK 8'h77
`define TLIC_LEVEL_WMASK 8'h7F
`define TLIC_BIT_GATE 7
`define TLIC_AUX_LVL_LSB 4
`define TLIC_NUM_SRC 11
`define TLIC_VEC_EXT0 16'h0003
`define TLIC_VEC_T0 16'h000B
`define TLIC_VEC_EXT1 16'h0013
`define TLIC_VEC_T1 16'h001B
`define TLIC_VEC_UART 16'h0023
`define TLIC_VEC_T2 16'h002B
`define TLIC_VEC_CONV 16'h0033
`define TLIC_VEC_SBUS 16'h003B
`define TLIC_VEC_PSM 16'h0043
`define TLIC_VEC_TIC 16'h0053
`define TLIC_VEC_WDT 16'h005B
`endif

// ===== verilog/tlic_pkg.sv
// Types shared by the interrupt controller files
package tlic_pkg;
  // Source index in polling order, 0 polled first
  typedef enum logic [3:0] {
    SRC_PSM, SRC_WDT, SRC_EXT0, SRC_CONV, SRC_T0, SRC_EXT1,
    SRC_T1, SRC_SBUS, SRC_UART, SRC_T2, SRC_TIC
  } tlic_src_t;
  // Register bus access from the core
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlic_sfr_req_t;
  // Result of the priority search
  typedef struct packed {
    logic found;
    logic [3:0] idx;
  } tlic_pick_t;
  // Controller state
  typedef enum {ST_IDLE, ST_WAIT_ACK} tlic_phase_t;
endpackage

// ===== verilog/tlic_picker.sv
// Fixed-order search for the first pending request in a mask
`timescale 1ns/1ps
`default_nettype none
module tlic_picker #(
  parameter int N = 11
) (
  input wire logic [N-1:0] req,
  output tlic_pkg::tlic_pick_t pick
);
  // Refuse widths that a four-bit index cannot name
  if (N < 1 || N > 16) begin : g_bad_width
    $error("tlic_picker: N out of range");
  end
  // Lowest index wins, so bit 0 is polled first
  always_comb begin
    pick = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick.found = 1'b1;
        pick.idx = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/tlic_vector_rom.sv
// Vector address lookup per source
`timescale 1ns/1ps
`default_nettype none
`include "tlic_defines.svh"
module tlic_vector_rom (
  input wire logic [3:0] idx,
  output logic [15:0] vector
);
  // Table in polling order
  always_comb begin
    case (idx)
      4'h0: vector = `TLIC_VEC_PSM;
      4'h1: vector = `TLIC_VEC_WDT;
      4'h2: vector = `TLIC_VEC_EXT0;
      4'h3: vector = `TLIC_VEC_CONV;
      4'h4: vector = `TLIC_VEC_T0;
      4'h5: vector = `TLIC_VEC_EXT1;
      4'h6: vector = `TLIC_VEC_T1;
      4'h7: vector = `TLIC_VEC_SBUS;
      4'h8: vector = `TLIC_VEC_UART;
      4'h9: vector = `TLIC_VEC_T2;
      4'hA: vector = `TLIC_VEC_TIC;
      default: vector = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

// ===== verilog/tlic_top.sv
// Two-level prioritised interrupt controller with its enable and level registers
`timescale 1ns/1ps
`default_nettype none
`include "tlic_defines.svh"
module tlic_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_value,
  output logic [7:0] sfr_rdata,
  input wire logic supply_monitor_irq,
  input wire logic watchdog_irq,
  input wire logic ext0_irq,
  input wire logic converter_irq,
  input wire logic timer0_overflow,
  input wire logic ext1_irq,
  input wire logic timer1_overflow,
  input wire logic spi_irq_flag,
  input wire logic i2c_irq_flag,
  input wire logic uart_receive_done,
  input wire logic uart_transmit_done,
  input wire logic timer2_overflow,
  input wire logic timer2_external_flag,
  input wire logic interval_counter_irq,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_request,
  output logic [15:0] irq_vector,
  output logic [3:0] irq_source,
  output logic [1:0] level_in_service
);
  // Number of sources, shared vectors counted once
  localparam int NSRC = `TLIC_NUM_SRC;
  // The picker and the source index are four bits wide
  if (NSRC > 16) begin : g_bad_count
    $error("tlic_top: too many sources");
  end

  // All state of the controller
  typedef struct packed {
    // Software-visible registers
    logic [7:0] irq_enable_mask; // Gate and seven enables
    logic [7:0] irq_level_select; // Seven level bits, bit 7 kept zero
    logic [7:0] aux_irq_enable_level; // Three levels, three enables
    // Levels now in service
    logic hi_active; // A high routine runs
    logic lo_active; // A low routine runs, maybe interrupted
    // Offer to the core
    logic req; // Offer stands
    logic [15:0] vector; // Vector of the offered source
    logic [3:0] source; // Index of the offered source
    logic taken_high; // Offered source is high level
  } tlic_state_t;

  // Registered state and its next value
  tlic_state_t state; // Current registers and offer
  tlic_state_t next_state; // Value taken at the next edge
  // Byte write request bundled for the decoder
  tlic_pkg::tlic_sfr_req_t sfr_req; // Strobe, address and data together
  // Per-source vectors, indexed in polling order
  logic [NSRC-1:0] pending; // Raw request lines, shared vectors merged
  logic [NSRC-1:0] enable_vec; // Individual enable per source
  logic [NSRC-1:0] level_vec; // One means high level
  // Requests that may be offered now, split by level
  logic [NSRC-1:0] hi_cand; // High level, not blocked
  logic [NSRC-1:0] lo_cand; // Low level, not blocked
  // Search results of the two pickers
  tlic_pkg::tlic_pick_t hi_pick; // First high candidate
  tlic_pkg::tlic_pick_t lo_pick; // First low candidate
  // Overall winner of this cycle
  logic [3:0] win_idx; // Source index of the winner
  logic win_high; // Winner is of high level
  logic win_found; // Any winner at all
  logic [15:0] win_vector; // Vector of the winner
  // Master gate from the enable register
  logic global_irq_gate; // Clear blocks every source

  // Bundle the byte write for the decoder
  assign sfr_req = '{wr: sfr_wr, addr: sfr_addr, wdata: sfr_wdata};

  // Set one bit of a byte, used by single-bit writes
  function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] sel, input logic b);
    logic [7:0] r;
    r = v;
    r[sel] = b;
    return r;
  endfunction

  // Stored form of a level value: the reserved top bit stays zero
  function automatic logic [7:0] level_store(input logic [7:0] v);
    return v & `TLIC_LEVEL_WMASK;
  endfunction

  // Request lines in polling order; shared vectors OR their flags
  always_comb begin
    // Flags are levels, cleared by their owners
    pending = '0;
    pending[tlic_pkg::SRC_PSM] = supply_monitor_irq;
    pending[tlic_pkg::SRC_WDT] = watchdog_irq;
    pending[tlic_pkg::SRC_EXT0] = ext0_irq;
    pending[tlic_pkg::SRC_CONV] = converter_irq;
    pending[tlic_pkg::SRC_T0] = timer0_overflow;
    pending[tlic_pkg::SRC_EXT1] = ext1_irq;
    pending[tlic_pkg::SRC_T1] = timer1_overflow;
    // Shared vectors: the routine tells the flags apart
    pending[tlic_pkg::SRC_SBUS] = spi_irq_flag | i2c_irq_flag;
    pending[tlic_pkg::SRC_UART] = uart_receive_done | uart_transmit_done;
    pending[tlic_pkg::SRC_T2] = timer2_overflow | timer2_external_flag;
    pending[tlic_pkg::SRC_TIC] = interval_counter_irq;
  end

  // Per-source enable and level, each from its own register bit except for the watchdog
  always_comb begin
    enable_vec = '0;
    level_vec = '0;
    // Watchdog has no enable or level bit: always enabled, kept high
    enable_vec[tlic_pkg::SRC_WDT] = 1'b1;
    level_vec[tlic_pkg::SRC_WDT] = 1'b1;
    // Main enable register, bits 0 to 6
    enable_vec[tlic_pkg::SRC_EXT0] = state.irq_enable_mask[0];
    enable_vec[tlic_pkg::SRC_T0] = state.irq_enable_mask[1];
    enable_vec[tlic_pkg::SRC_EXT1] = state.irq_enable_mask[2];
    enable_vec[tlic_pkg::SRC_T1] = state.irq_enable_mask[3];
    enable_vec[tlic_pkg::SRC_UART] = state.irq_enable_mask[4];
    enable_vec[tlic_pkg::SRC_T2] = state.irq_enable_mask[5];
    enable_vec[tlic_pkg::SRC_CONV] = state.irq_enable_mask[6];
    // Aux register, bits 0 to 2
    enable_vec[tlic_pkg::SRC_SBUS] = state.aux_irq_enable_level[0];
    enable_vec[tlic_pkg::SRC_PSM] = state.aux_irq_enable_level[1];
    enable_vec[tlic_pkg::SRC_TIC] = state.aux_irq_enable_level[2];
    // Level register, bits 0 to 6
    level_vec[tlic_pkg::SRC_EXT0] = state.irq_level_select[0];
    level_vec[tlic_pkg::SRC_T0] = state.irq_level_select[1];
    level_vec[tlic_pkg::SRC_EXT1] = state.irq_level_select[2];
    level_vec[tlic_pkg::SRC_T1] = state.irq_level_select[3];
    level_vec[tlic_pkg::SRC_UART] = state.irq_level_select[4];
    level_vec[tlic_pkg::SRC_T2] = state.irq_level_select[5];
    level_vec[tlic_pkg::SRC_CONV] = state.irq_level_select[6];
    // Aux register, bits 4 to 6
    level_vec[tlic_pkg::SRC_SBUS] = state.aux_irq_enable_level[`TLIC_AUX_LVL_LSB];
    level_vec[tlic_pkg::SRC_PSM] = state.aux_irq_enable_level[`TLIC_AUX_LVL_LSB + 1];
    level_vec[tlic_pkg::SRC_TIC] = state.aux_irq_enable_level[`TLIC_AUX_LVL_LSB + 2];
  end

  // Bit 7 of the enable register gates every source
  assign global_irq_gate = state.irq_enable_mask[`TLIC_BIT_GATE];

  // Candidates per level; the gate blocks everything when clear
  always_comb begin
    hi_cand = '0;
    lo_cand = '0;
    if (global_irq_gate) begin
      // High may run unless a high routine is active
      if (!state.hi_active) begin
        hi_cand = pending & enable_vec & level_vec;
      end
      // Low only when no routine of either level is active
      // A held-off request waits here until a return
      if (!state.hi_active && !state.lo_active) begin
        lo_cand = pending & enable_vec & ~level_vec;
      end
    end
  end

  // Polling order search among high candidates
  tlic_picker #(.N(NSRC)) u_hi_pick (
    .req(hi_cand),
    .pick(hi_pick)
  );

  // Same search among low candidates
  tlic_picker #(.N(NSRC)) u_lo_pick (
    .req(lo_cand),
    .pick(lo_pick)
  );

  // High level beats low in the same cycle
  always_comb begin
    win_found = hi_pick.found | lo_pick.found;
    win_high = hi_pick.found;
    // Low index used only when no high one is found
    win_idx = hi_pick.found ? hi_pick.idx : lo_pick.idx;
  end

  // Vector of the winner, latched with the offer
  tlic_vector_rom u_vec (
    .idx(win_idx),
    .vector(win_vector)
  );

  // Next-state logic: register writes, request offer, service tracking
  always_comb begin
    next_state = state;
    // Byte writes; aux not reachable by single-bit writes
    // Byte write and bit write in one cycle: the byte write wins
    if (sfr_req.wr) begin
      case (sfr_req.addr)
        `TLIC_ADDR_ENABLE: next_state.irq_enable_mask = sfr_req.wdata;
        `TLIC_ADDR_LEVEL: next_state.irq_level_select = level_store(sfr_req.wdata);
        // Bit 3 and reserved bits are not stored; bit 7 reads back as one
        `TLIC_ADDR_AUX: next_state.aux_irq_enable_level =
          (sfr_req.wdata & `TLIC_AUX_WMASK) | (`TLIC_RST_AUX & ~`TLIC_AUX_WMASK);
        default: next_state = next_state;
      endcase
    end else if (bit_wr) begin
      // Bit writes reach only the enable and level registers
      case (bit_addr)
        `TLIC_ADDR_ENABLE: next_state.irq_enable_mask = put_bit(state.irq_enable_mask, bit_sel, bit_value);
        `TLIC_ADDR_LEVEL: next_state.irq_level_select =
          level_store(put_bit(state.irq_level_select, bit_sel, bit_value));
        default: next_state = next_state;
      endcase
    end
    // Return frees the highest active level first
    if (irq_return) begin
      if (state.hi_active) begin
        // Nested case: the high routine ends first
        next_state.hi_active = 1'b0;
      end else begin
        // Only a low routine was running
        next_state.lo_active = 1'b0;
      end
    end
    // Acceptance marks the level in service and drops the offer
    if (irq_ack && state.req) begin
      // Level recorded is the one offered, not recomputed
      if (state.taken_high) begin
        next_state.hi_active = 1'b1;
      end else begin
        next_state.lo_active = 1'b1;
      end
      // Offer ends; the core has pushed its counter
      next_state.req = 1'b0;
    end else begin
      // Offer follows the current winner, so a later high one replaces it
      next_state.req = win_found;
      // Vector is held when nothing wins
      if (win_found) begin
        next_state.vector = win_vector;
        next_state.source = win_idx;
        next_state.taken_high = win_high;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Registers to their power-on values
      state.irq_enable_mask <= `TLIC_RST_ENABLE;
      state.irq_level_select <= `TLIC_RST_LEVEL;
      state.aux_irq_enable_level <= `TLIC_RST_AUX;
      // No level in service and no offer
      state.hi_active <= 1'b0;
      state.lo_active <= 1'b0;
      state.req <= 1'b0;
      state.vector <= 16'h0000;
      state.source <= 4'h0;
      state.taken_high <= 1'b0;
    end else begin
      // One copy of the whole state per edge
      state <= next_state;
    end
  end

  // Read mux; unmapped addresses read zero
  // Reads need no strobe and have no side effect
  always_comb begin
    case (sfr_addr)
      `TLIC_ADDR_ENABLE: sfr_rdata = state.irq_enable_mask;
      `TLIC_ADDR_LEVEL: sfr_rdata = state.irq_level_select;
      `TLIC_ADDR_AUX: sfr_rdata = state.aux_irq_enable_level;
      // A stray read is harmless
      default: sfr_rdata = 8'h00;
    endcase
  end

  // Outputs straight from the state flip-flops
  assign irq_request = state.req;
  assign irq_vector = state.vector;
  assign irq_source = state.source;
  assign level_in_service = {state.hi_active, state.lo_active};
endmodule
`default_nettype wire

// ===== dv/tlic_checker.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tlic_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0] irq_source,
  input wire logic [1:0] level_in_service
);
  // Vectors in polling order, kept apart from the design's own table
  localparam logic [15:0] VEC [0:10] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B,
    16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Core takes the offer
  sequence s_accept;
    irq_request && irq_ack;
  endsequence
  // Return with no accept beside it
  sequence s_ret_only;
    irq_return && !irq_ack;
  endsequence
  // After a lone return the top active level is gone
  property p_return_frees;
    s_ret_only |=> level_in_service ==
      ($past(level_in_service[1]) ? {1'b0, $past(level_in_service[0])} : 2'b00);
  endproperty
  // Offered vector belongs to the offered source
  property p_vector_match;
    irq_request |-> irq_source <= 4'hA && irq_vector == VEC[irq_source];
  endproperty
  // An aux write reads back masked, top bit set
  property p_aux_lands;
    sfr_wr && sfr_addr == 8'hA9 |=> sfr_addr != 8'hA9 || sfr_rdata == (($past(sfr_wdata) & 8'h77) | 8'h80);
  endproperty
  a_high_blocks_all: assert property (level_in_service[1] |-> !irq_request)
    else $error("request offered while high level in service");
  a_ack_drops_req: assert property (s_accept |=> !irq_request)
    else $error("request still offered after accept");
  a_ack_marks_level: assert property (s_accept |=> level_in_service != 2'b00)
    else $error("accepted level not recorded");
  a_return_frees_top: assert property (p_return_frees)
    else $error("return freed wrong level");
  a_vector_of_source: assert property (p_vector_match)
    else $error("vector does not match source");
  a_aux_fixed_bits: assert property (sfr_addr == 8'hA9 |-> sfr_rdata[7] && !sfr_rdata[3])
    else $error("aux reserved bits wrong");
  a_level_bit_seven: assert property (sfr_addr == 8'hB8 |-> !sfr_rdata[7])
    else $error("level reserved bit set");
  a_aux_write_lands: assert property (p_aux_lands)
    else $error("aux write not stored");
endmodule
bind tlic_top tlic_checker i_chk (.clk, .rst_b, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata, .irq_ack,
  .irq_return, .irq_request, .irq_vector, .irq_source, .level_in_service);
`default_nettype wire

// ===== dv/tlic_core_model.sv
// Behavioural core that accepts offered vectors and returns from them
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic ack_en,
  input wire logic ret_go,
  output logic irq_ack,
  output logic irq_return,
  output logic [15:0] pc
);
  // Ack only while allowed, so the bench can make the core slow
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      pc <= 16'h0000;
    end else begin
      irq_ack <= irq_request && ack_en && !irq_ack;
      irq_return <= ret_go;
      // Jump to the offered vector in the accepting cycle
      if (irq_request && irq_ack) begin
        pc <= irq_vector;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  // One case: registers, request lines, expected offer
  typedef struct packed {
    logic [7:0] en, lvl, aux;
    logic [13:0] req;
    logic [15:0] vec;
    logic [3:0] src;
    logic [1:0] ls;
  } tlic_tb_row_t;
  // Request bits: psm wdt ext0 conv t0 ext1 t1 spi i2c ri ti tf2 timer2_external_flag tic; src F means none
  tlic_tb_row_t rows [0:18] = '{
    '{8'hFF, 8'h00, 8'h07, 14'h3FFF, 16'h005B, 4'h1, 2'h2}, '{8'hFF, 8'h00, 8'h07, 14'h2FFF, 16'h0043, 4'h0, 2'h1},
    '{8'hFF, 8'h00, 8'h07, 14'h0FFF, 16'h0003, 4'h2, 2'h1}, '{8'hFF, 8'h00, 8'h07, 14'h07FF, 16'h0033, 4'h3, 2'h1},
    '{8'hFF, 8'h00, 8'h07, 14'h03FF, 16'h000B, 4'h4, 2'h1}, '{8'hFF, 8'h00, 8'h07, 14'h01FF, 16'h0013, 4'h5, 2'h1},
    '{8'hFF, 8'h00, 8'h07, 14'h00FF, 16'h001B, 4'h6, 2'h1}, '{8'hFF, 8'h00, 8'h07, 14'h0020, 16'h003B, 4'h7, 2'h1},
    '{8'hFF, 8'h00, 8'h07, 14'h0040, 16'h003B, 4'h7, 2'h1}, '{8'hFF, 8'h00, 8'h07, 14'h0008, 16'h0023, 4'h8, 2'h1},
    '{8'hFF, 8'h00, 8'h07, 14'h0010, 16'h0023, 4'h8, 2'h1}, '{8'hFF, 8'h00, 8'h07, 14'h0002, 16'h002B, 4'h9, 2'h1},
    '{8'hFF, 8'h00, 8'h07, 14'h0004, 16'h002B, 4'h9, 2'h1}, '{8'hFF, 8'h00, 8'h07, 14'h0001, 16'h0053, 4'hA, 2'h1},
    '{8'hFF, 8'h00, 8'h47, 14'h0801, 16'h0053, 4'hA, 2'h2}, '{8'hFF, 8'h40, 8'h07, 14'h0C00, 16'h0033, 4'h3, 2'h2},
    '{8'h7F, 8'h00, 8'h07, 14'h0800, 16'h0000, 4'hF, 2'h0}, '{8'hFF, 8'h00, 8'h06, 14'h0040, 16'h0000, 4'hF, 2'h0},
    '{8'hFE, 8'h00, 8'h07, 14'h0800, 16'h0000, 4'hF, 2'h0}};
  logic clk = 1'b0, rst_b, sfr_wr, bit_wr, bit_value, ack_en, ret_go, irq_ack, irq_return, irq_request;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata;
  logic [2:0] bit_sel;
  logic [13:0] req;
  logic [15:0] irq_vector, pc;
  logic [3:0] irq_source;
  logic [1:0] level_in_service;
  int n_fail = 0, num_checks = 0;
  // 25 ns core clock
  always #12.5 clk = ~clk;
  tlic_top i_dut (.clk, .rst_b, .sfr_wr, .sfr_addr, .sfr_wdata, .bit_wr, .bit_addr, .bit_sel, .bit_value,
    .sfr_rdata, .supply_monitor_irq(req[13]), .watchdog_irq(req[12]), .ext0_irq(req[11]),
    .converter_irq(req[10]), .timer0_overflow(req[9]), .ext1_irq(req[8]), .timer1_overflow(req[7]),
    .spi_irq_flag(req[6]), .i2c_irq_flag(req[5]), .uart_receive_done(req[4]), .uart_transmit_done(req[3]),
    .timer2_overflow(req[2]), .timer2_external_flag(req[1]), .interval_counter_irq(req[0]), .irq_ack,
    .irq_return, .irq_request, .irq_vector, .irq_source, .level_in_service);
  tlic_core_model i_core (.clk, .rst_b, .irq_request, .irq_vector, .ack_en, .ret_go, .irq_ack,
    .irq_return, .pc);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Byte write; strobe dropped on the following edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
    @(posedge clk) sfr_wr <= 1'b0;
  endtask
  task automatic bitwr(input logic [7:0] a, input logic [2:0] s, input logic v);
    @(posedge clk) {bit_wr, bit_addr, bit_sel, bit_value} <= {1'b1, a, s, v};
    @(posedge clk) bit_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) sfr_addr <= a;
    @(negedge clk) chk({8'h00, sfr_rdata}, {8'h00, e});
  endtask
  // Bounded wait for an offer, then compare it
  task automatic offer(input logic [15:0] v, input logic [3:0] s);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      if (irq_request === 1'b1) break;
    end
    chk({15'h0, irq_request}, {15'h0, s != 4'hF});
    if (s != 4'hF) begin
      chk(irq_vector, v);
      chk({12'h0, irq_source}, {12'h0, s});
    end
  endtask
  // Let the core accept, holding back until it does
  task automatic accept(input logic [1:0] ls);
    @(posedge clk) ack_en <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      if (irq_ack === 1'b1) break;
    end
    @(posedge clk) ack_en <= 1'b0;
    @(negedge clk) chk({14'h0, level_in_service}, {14'h0, ls});
  endtask
  task automatic retire(input logic [1:0] ls);
    @(posedge clk) ret_go <= 1'b1;
    @(posedge clk) ret_go <= 1'b0;
    repeat (2) @(negedge clk);
    chk({14'h0, level_in_service}, {14'h0, ls});
  endtask
  // Hang guard, well above the expected run
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  initial begin
    {rst_b, sfr_wr, bit_wr, bit_value, ack_en, ret_go, bit_sel} = '0;
    {sfr_addr, sfr_wdata, bit_addr, req} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'hA8, 8'h00);
    rd(8'hB8, 8'h00);
    rd(8'hA9, 8'hA0);
    // Table cases: bit 3 of aux always written as zero
    foreach (rows[i]) begin
      wr(8'hA8, rows[i].en);
      wr(8'hB8, rows[i].lvl);
      wr(8'hA9, rows[i].aux);
      @(posedge clk) req <= rows[i].req;
      offer(rows[i].vec, rows[i].src);
      if (rows[i].src != 4'hF) begin
        accept(rows[i].ls);
        chk(pc, rows[i].vec);
      end
      @(posedge clk) req <= '0;
      if (rows[i].src != 4'hF) retire(2'h0);
    end
    // Nesting: low running, same level held off, high preempts
    wr(8'hA8, 8'hFF);
    wr(8'hB8, 8'h00);
    @(posedge clk) req <= 14'h0800;
    offer(16'h0003, 4'h2);
    accept(2'h1);
    @(posedge clk) req <= 14'h0080;
    offer(16'h0000, 4'hF);
    wr(8'hB8, 8'h08);
    offer(16'h001B, 4'h6);
    accept(2'h3);
    chk(pc, 16'h001B);
    @(posedge clk) req <= '0;
    retire(2'h1);
    retire(2'h0);
    // Register corners
    wr(8'hA9, 8'hFF);
    rd(8'hA9, 8'hF7);
    bitwr(8'hA9, 3'h0, 1'b0);
    rd(8'hA9, 8'hF7);
    wr(8'hB8, 8'hFF);
    rd(8'hB8, 8'h7F);
    bitwr(8'hB8, 3'h7, 1'b1);
    bitwr(8'hB8, 3'h0, 1'b0);
    rd(8'hB8, 8'h7E);
    bitwr(8'hA8, 3'h7, 1'b0);
    rd(8'hA8, 8'h7F);
    rd(8'h00, 8'h00);
    @(posedge clk) rst_b <= 1'b0;
    rd(8'hA9, 8'hA0);
    @(posedge clk) rst_b <= 1'b1;
    rd(8'hA8, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
